// [core/scro_top.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Range enable: inclusive bound check per character
// - Range hit posts exception, status 111
// - High pair enable gates third/fourth compare
// - Transparent mode keeps flow characters out
// - Withheld flow characters still pause/resume transmit
// - Visible mode: act, store, post exception
// - Low pair enable gates first/second compare
// - Threshold field is direct count 1..12
// - Stop-off pauses; resume on on-char or any
`include "scro_defs.svh"
module scro_top
    import scro_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Received characters from the deserialiser
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    // Transmit flow and service requests
    output logic tx_paused,
    output logic rx_data_req,
    output logic rx_exc_req,
    output logic irq
);

    scro_state_t st_ff;
    scro_state_t nxt_st;
    scro_cmp_if cif();

    logic do_write;
    logic do_read;
    logic pop;
    logic push;
    logic flow_char;
    logic [`SCRO_INT_W-1:0] int_set;
    logic [`SCRO_INT_W-1:0] int_clr;
    logic [3:0] thr;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        return (p == `SCRO_PTR_LAST) ? 4'h0 : 4'(p + 4'h1);
    endfunction

    function automatic logic idx_mapped(input logic [7:0] idx);
        return (idx == `SCRO_IDX_RX_DATA) || (idx == `SCRO_IDX_RX_LEVEL) || (idx == `SCRO_IDX_EXCEPT) ||
               (idx == `SCRO_IDX_FLOW_CTRL) || (idx == `SCRO_IDX_MATCH) || (idx == `SCRO_IDX_RANGE) ||
               (idx == `SCRO_IDX_INT_STAT) || (idx == `SCRO_IDX_INT_CLR) || (idx == `SCRO_IDX_INT_EN) ||
               (idx == `SCRO_IDX_OPTION3);
    endfunction

    // ****************************************
    // Character classifier
    // ****************************************
    assign cif.rx_char = rx_char;
    assign cif.match_value = st_ff.match_value;
    assign cif.range_lo = st_ff.range_lo;
    assign cif.range_hi = st_ff.range_hi;
    assign cif.range_detect_enable = st_ff.option3[`SCRO_OPT3_RANGE_BIT];
    assign cif.compare_pair_high_enable = st_ff.option3[`SCRO_OPT3_PAIR_HI_BIT];
    assign cif.compare_pair_low_enable = st_ff.option3[`SCRO_OPT3_PAIR_LO_BIT];

    scro_cmp u_cmp (
        .cif(cif.cmp)
    );

    // ****************************************
    // Bus handshakes and outputs
    // ****************************************
    assign s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_have && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    assign tx_paused = st_ff.tx_paused;
    assign rx_exc_req = st_ff.int_stat[`SCRO_INT_EXCEPT_BIT];
    assign irq = |(st_ff.int_stat & st_ff.int_en);

    // Codes above the FIFO depth are legal but can never be met
    // Direct count, zero unused
    assign thr = st_ff.option3[`SCRO_OPT3_THR_MSB:`SCRO_OPT3_THR_LSB];
    assign rx_data_req = (thr != 4'h0) && (st_ff.count >= thr);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        do_write = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
        do_read = s_axi_arvalid && !st_ff.rvalid;
        pop = 1'b0;
        push = 1'b0;
        int_set = '0;
        int_clr = '0;
        flow_char = cif.is_xon || cif.is_xoff;

        // ****************************************
        // Write channel capture
        // ****************************************
        // Address and data are held apart, so either may arrive first
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // ****************************************
        // Register writes
        // ****************************************
        if (do_write) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = idx_mapped(st_ff.aw_idx) ? `SCRO_RESP_OKAY : `SCRO_RESP_SLVERR;
            case (st_ff.aw_idx)
                `SCRO_IDX_OPTION3: begin
                    // Only lane 0 exists; the upper lanes are reserved
                    if (st_ff.wstrb[0]) begin
                        nxt_st.option3 = st_ff.wdata[7:0];
                    end
                end
                `SCRO_IDX_FLOW_CTRL: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.inband_tx_flow_enable = st_ff.wdata[`SCRO_FLOW_INBAND_BIT];
                        nxt_st.implied_resume_mode = st_ff.wdata[`SCRO_FLOW_IMPLIED_BIT];
                    end
                end
                `SCRO_IDX_MATCH: begin
                    nxt_st.match_value = merge(st_ff.match_value, st_ff.wdata, st_ff.wstrb);
                end
                `SCRO_IDX_RANGE: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.range_lo = st_ff.wdata[7:0];
                    end
                    if (st_ff.wstrb[1]) begin
                        nxt_st.range_hi = st_ff.wdata[15:8];
                    end
                end
                `SCRO_IDX_INT_EN: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.int_en = st_ff.wdata[`SCRO_INT_W-1:0];
                    end
                end
                `SCRO_IDX_INT_CLR: begin
                    if (st_ff.wstrb[0]) begin
                        int_clr = st_ff.wdata[`SCRO_INT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ****************************************
        // Register reads
        // ****************************************
        // Address is decoded straight off the bus; arready stays low while rvalid stands
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (do_read) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = '0;
            nxt_st.rresp = idx_mapped(s_axi_araddr[9:2]) ? `SCRO_RESP_OKAY : `SCRO_RESP_SLVERR;
            case (s_axi_araddr[9:2])
                `SCRO_IDX_RX_DATA: begin
                    // Reading an empty FIFO returns zero and changes nothing
                    if (st_ff.count != 4'h0) begin
                        nxt_st.rdata[7:0] = st_ff.fifo[st_ff.rptr];
                        pop = 1'b1;
                    end
                end
                `SCRO_IDX_RX_LEVEL: nxt_st.rdata[3:0] = st_ff.count;
                `SCRO_IDX_EXCEPT: nxt_st.rdata = {21'h0, st_ff.match_status_field, st_ff.exc_char};
                `SCRO_IDX_FLOW_CTRL: begin
                    nxt_st.rdata[`SCRO_FLOW_INBAND_BIT] = st_ff.inband_tx_flow_enable;
                    nxt_st.rdata[`SCRO_FLOW_IMPLIED_BIT] = st_ff.implied_resume_mode;
                    nxt_st.rdata[`SCRO_FLOW_PAUSED_BIT] = st_ff.tx_paused;
                end
                `SCRO_IDX_MATCH: nxt_st.rdata = st_ff.match_value;
                `SCRO_IDX_RANGE: nxt_st.rdata = {16'h0, st_ff.range_hi, st_ff.range_lo};
                `SCRO_IDX_INT_STAT: nxt_st.rdata[`SCRO_INT_W-1:0] = st_ff.int_stat;
                `SCRO_IDX_INT_EN: nxt_st.rdata[`SCRO_INT_W-1:0] = st_ff.int_en;
                `SCRO_IDX_OPTION3: nxt_st.rdata[7:0] = st_ff.option3;
                default: begin
                end
            endcase
        end

        // ****************************************
        // Receive path
        // ****************************************
        if (rx_valid) begin
            if (st_ff.inband_tx_flow_enable) begin
                if (cif.is_xoff) begin
                    nxt_st.tx_paused = 1'b1;
                end else if (cif.is_xon || st_ff.implied_resume_mode) begin
                    nxt_st.tx_paused = 1'b0;
                end
            end
            if (!(flow_char && st_ff.option3[`SCRO_OPT3_TRANSP_BIT])) begin
                push = 1'b1;
                if (cif.code != SCRO_CODE_NONE) begin
                    nxt_st.match_status_field = cif.code;
                    nxt_st.exc_char = rx_char;
                    int_set[`SCRO_INT_EXCEPT_BIT] = 1'b1;
                end
            end
        end

        // ****************************************
        // FIFO bookkeeping
        // ****************************************
        // A pop in the same cycle frees a slot, so a full FIFO can still take the push
        if (push && (st_ff.count == 4'(`SCRO_FIFO_DEPTH)) && !pop) begin
            push = 1'b0;
            int_set[`SCRO_INT_OVRUN_BIT] = 1'b1;
        end
        if (push) begin
            nxt_st.fifo[st_ff.wptr] = rx_char;
            nxt_st.wptr = ptr_inc(st_ff.wptr);
        end
        if (pop) begin
            nxt_st.rptr = ptr_inc(st_ff.rptr);
        end
        if (push && !pop) begin
            nxt_st.count = 4'(st_ff.count + 4'h1);
        end else if (pop && !push) begin
            nxt_st.count = 4'(st_ff.count - 4'h1);
        end

        // ****************************************
        // Status flags
        // ****************************************
        // Data request sets sticky bit
        int_set[`SCRO_INT_DATA_BIT] = rx_data_req;
        // Set wins over a clear in the same cycle
        nxt_st.int_stat = (st_ff.int_stat & ~int_clr) | int_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.option3 <= `SCRO_OPT3_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// [core/scro_defs.svh]
`ifndef SCRO_DEFS_SVH
`define SCRO_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define SCRO_IDX_RX_DATA   8'h00
`define SCRO_IDX_RX_LEVEL  8'h01
`define SCRO_IDX_EXCEPT    8'h02
`define SCRO_IDX_FLOW_CTRL 8'h03
`define SCRO_IDX_MATCH     8'h04
`define SCRO_IDX_RANGE     8'h05
`define SCRO_IDX_INT_STAT  8'h06
`define SCRO_IDX_INT_CLR   8'h07
`define SCRO_IDX_INT_EN    8'h08
`define SCRO_IDX_OPTION3   8'h0a

// ****************************************
// Option register three fields
// ****************************************
`define SCRO_OPT3_RANGE_BIT   7
`define SCRO_OPT3_PAIR_HI_BIT 6
`define SCRO_OPT3_TRANSP_BIT  5
`define SCRO_OPT3_PAIR_LO_BIT 4
`define SCRO_OPT3_THR_MSB     3
`define SCRO_OPT3_THR_LSB     0
`define SCRO_OPT3_RESET       8'h00

// ****************************************
// Flow control register fields
// ****************************************
`define SCRO_FLOW_INBAND_BIT  0
`define SCRO_FLOW_IMPLIED_BIT 1
`define SCRO_FLOW_PAUSED_BIT  8

// ****************************************
// Interrupt bits and other resets
// ****************************************
`define SCRO_INT_DATA_BIT   0
`define SCRO_INT_EXCEPT_BIT 1
`define SCRO_INT_OVRUN_BIT  2
`define SCRO_INT_W          3
`define SCRO_ZERO_RESET     32'h0000_0000

// ****************************************
// Receive FIFO and bus answers
// ****************************************
`define SCRO_FIFO_DEPTH 12
`define SCRO_PTR_LAST   4'hb
`define SCRO_RESP_OKAY  2'h0
`define SCRO_RESP_SLVERR 2'h2

`endif

// [core/scro_pkg.sv]
package scro_pkg;
`include "scro_defs.svh"

    typedef enum logic [2:0] {
        SCRO_CODE_NONE  = 3'b000,
        SCRO_CODE_ONE   = 3'b001,
        SCRO_CODE_TWO   = 3'b010,
        SCRO_CODE_THREE = 3'b011,
        SCRO_CODE_FOUR  = 3'b100,
        SCRO_CODE_RANGE = 3'b111
    } scro_code_t;

    typedef struct packed {
        logic [7:0] option3;
        logic inband_tx_flow_enable;
        logic implied_resume_mode;
        logic [3:0][7:0] match_value;
        logic [7:0] range_lo;
        logic [7:0] range_hi;
        logic [`SCRO_INT_W-1:0] int_stat;
        logic [`SCRO_INT_W-1:0] int_en;
        logic [`SCRO_FIFO_DEPTH-1:0][7:0] fifo;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [3:0] count;
        logic tx_paused;
        logic [2:0] match_status_field;
        logic [7:0] exc_char;
        logic aw_have;
        logic [7:0] aw_idx;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scro_state_t;
endpackage

// [core/scro_cmp_if.sv]
`timescale 1ns/1ns
interface scro_cmp_if;
    import scro_pkg::*;
    logic [7:0] rx_char;
    logic [3:0][7:0] match_value;
    logic [7:0] range_lo;
    logic [7:0] range_hi;
    logic range_detect_enable;
    logic compare_pair_low_enable;
    logic compare_pair_high_enable;
    scro_code_t code;
    logic is_xon;
    logic is_xoff;

    modport cmp (
        input rx_char, match_value, range_lo, range_hi,
        input range_detect_enable, compare_pair_low_enable, compare_pair_high_enable,
        output code, is_xon, is_xoff
    );
    modport user (
        output rx_char, match_value, range_lo, range_hi,
        output range_detect_enable, compare_pair_low_enable, compare_pair_high_enable,
        input code, is_xon, is_xoff
    );
endinterface

// [core/scro_cmp.sv]
`timescale 1ns/1ns
module scro_cmp
    import scro_pkg::*;
(
    // Character classification
    scro_cmp_if.cmp cif
);

    function automatic logic same_char(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    logic [3:0] hit;
    logic in_range;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_cmp
            if (i < 2) begin : g_lo
                assign hit[i] = cif.compare_pair_low_enable && same_char(cif.rx_char, cif.match_value[i]);
            end else begin : g_hi
                assign hit[i] = cif.compare_pair_high_enable && same_char(cif.rx_char, cif.match_value[i]);
            end
        end
    endgenerate

    assign in_range = cif.range_detect_enable && (cif.rx_char >= cif.range_lo) && (cif.rx_char <= cif.range_hi);

    // Flow characters exist only while the low pair compare is on
    assign cif.is_xon = hit[0];
    assign cif.is_xoff = hit[1];

    always_comb begin
        cif.code = SCRO_CODE_NONE;
        if (hit[0]) begin
            cif.code = SCRO_CODE_ONE;
        end else if (hit[1]) begin
            cif.code = SCRO_CODE_TWO;
        end else if (hit[2]) begin
            cif.code = SCRO_CODE_THREE;
        end else if (hit[3]) begin
            cif.code = SCRO_CODE_FOUR;
        end else if (in_range) begin
            cif.code = SCRO_CODE_RANGE;
        end
    end
endmodule

// [verification/scro_top_assertions.sv]
`timescale 1ns/1ns
module scro_top_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Receive link and requests
    input wire logic rx_valid,
    input wire logic tx_paused,
    input wire logic rx_data_req,
    input wire logic rx_exc_req
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answer_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while busy");
    a_exc_from_char: assert property ($rose(rx_exc_req) |-> $past(rx_valid))
        else $error("exception without a character");
    a_exc_held_sticky: assert property ($fell(rx_exc_req) |-> s_axi_bvalid)
        else $error("exception request fell without a write");
    a_pause_from_char: assert property ($rose(tx_paused) |-> $past(rx_valid))
        else $error("pause without a character");
    a_req_drop_cause: assert property ($fell(rx_data_req) |-> s_axi_rvalid || s_axi_bvalid)
        else $error("data request fell without an access");
endmodule

bind scro_top scro_top_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .rx_valid, .tx_paused, .rx_data_req, .rx_exc_req);

// [verification/scro_remote.sv]
`timescale 1ns/1ns
module scro_remote (
    // Clock
    aclk,
    // Receive link
    rx_valid,
    rx_char
);
    input wire logic aclk;
    output logic rx_valid;
    output logic [7:0] rx_char;

    initial begin
        rx_valid = 1'b0;
        rx_char = 8'h00;
    end

    // Idle line shows the inverse so a stale byte never passes for data
    task automatic send(input logic [7:0] c);
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_char <= c;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
    endtask
endmodule

// [verification/serial_rx_special_char_option_tb.sv]
`timescale 1ns/1ns
`include "scro_defs.svh"
module serial_rx_special_char_option_tb;
    import scro_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, tx_paused, rx_data_req;
    logic rx_exc_req, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, hs;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] rx_char;
    int err_count, total_checks;

    scro_top u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_valid, .rx_char, .tx_paused, .rx_data_req,
        .rx_exc_req, .irq);
    scro_remote u_rem (.aclk, .rx_valid, .rx_char);

    always #25 aclk = ~aclk;
    assign hs = {s_axi_awready && s_axi_wready, s_axi_bvalid, s_axi_rvalid, s_axi_arready};

    task automatic end_sim();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Handshakes are read just after the edge, so they show the sampled values
    task automatic wait_for(input int which);
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (hs[which] === 1'b1) begin
                return;
            end
        end
        err_count++;
        $display("CHECK FAILED at %0t: bus handshake timeout", $time);
        end_sim();
    endtask

    task automatic axw(input logic [7:0] idx, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        wait_for(3);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        wait_for(2);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] idx);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_rready <= 1'b1;
        wait_for(0);
        s_axi_arvalid <= 1'b0;
        wait_for(1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic run_case(input logic [7:0] opt, input logic [7:0] ch, input logic exc, input logic [2:0] code,
                            input logic keep);
        axw(`SCRO_IDX_OPTION3, {24'h0000_00, opt});
        u_rem.send(ch);
        repeat (2) @(posedge aclk);
        axr(`SCRO_IDX_INT_STAT);
        chk(rd[1], exc, "exception flag");
        chk(rx_exc_req, exc, "exception request");
        if (exc) begin
            axr(`SCRO_IDX_EXCEPT);
            chk(rd[10:0], {code, ch}, "exception status");
        end
        axr(`SCRO_IDX_RX_LEVEL);
        chk(rd[3:0], keep, "fifo level");
        if (keep) begin
            axr(`SCRO_IDX_RX_DATA);
            chk(rd[7:0], ch, "stored character");
        end
        axw(`SCRO_IDX_INT_CLR, 32'h0000_0007);
    endtask

    initial begin
        {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(`SCRO_IDX_OPTION3);
        chk(rd, `SCRO_OPT3_RESET, "option reset value");
        axr(8'h3f);
        chk(rr, `SCRO_RESP_SLVERR, "unmapped read");
        axw(8'h3f, 32'h0000_0000);
        chk(rr, `SCRO_RESP_SLVERR, "unmapped write");
        axw(`SCRO_IDX_OPTION3, 32'h0000_00a5);
        chk(rr, `SCRO_RESP_OKAY, "mapped write");
        axr(`SCRO_IDX_OPTION3);
        chk(rd, 32'h0000_00a5, "option readback");
        axw(`SCRO_IDX_MATCH, 32'h4241_1311);
        axw(`SCRO_IDX_RANGE, 32'h0000_3930);
        axr(`SCRO_IDX_RANGE);
        chk(rd, 32'h0000_3930, "range bounds readback");
        axw(`SCRO_IDX_INT_EN, 32'h0000_0007);
        run_case(8'h00, 8'h41, 1'b0, 3'b000, 1'b1);
        run_case(8'h40, 8'h41, 1'b1, 3'b011, 1'b1);
        run_case(8'h40, 8'h42, 1'b1, 3'b100, 1'b1);
        run_case(8'h80, 8'h30, 1'b1, 3'b111, 1'b1);
        run_case(8'h80, 8'h39, 1'b1, 3'b111, 1'b1);
        run_case(8'h80, 8'h3a, 1'b0, 3'b000, 1'b1);
        run_case(8'h80, 8'h2f, 1'b0, 3'b000, 1'b1);
        run_case(8'h00, 8'h13, 1'b0, 3'b000, 1'b1);
        run_case(8'h10, 8'h11, 1'b1, 3'b001, 1'b1);
        // Cases below set the low pair enable bit while in-band flow is on
        axw(`SCRO_IDX_FLOW_CTRL, 32'h0000_0001);
        run_case(8'h30, 8'h13, 1'b0, 3'b000, 1'b0);
        chk(tx_paused, 1'b1, "pause on withheld stop");
        run_case(8'h30, 8'h11, 1'b0, 3'b000, 1'b0);
        chk(tx_paused, 1'b0, "resume on withheld start");
        run_case(8'h10, 8'h13, 1'b1, 3'b010, 1'b1);
        chk(tx_paused, 1'b1, "pause on visible stop");
        axr(`SCRO_IDX_FLOW_CTRL);
        chk(rd[`SCRO_FLOW_PAUSED_BIT], 1'b1, "paused flag");
        axw(`SCRO_IDX_FLOW_CTRL, 32'h0000_0003);
        run_case(8'h10, 8'h41, 1'b0, 3'b000, 1'b1);
        chk(tx_paused, 1'b0, "implied resume");
        // In-band flow is still on, and option bit 4 keeps the low pair enabled here too
        axw(`SCRO_IDX_OPTION3, 32'h0000_001b);
        for (int i = 1; i <= 12; i++) begin
            u_rem.send(i[7:0]);
            repeat (2) @(posedge aclk);
            chk(rx_data_req, i >= 11, "data request level");
        end
        chk(irq, 1'b1, "interrupt raised");
        u_rem.send(8'hee);
        repeat (2) @(posedge aclk);
        axr(`SCRO_IDX_INT_STAT);
        chk(rd[2:0], 3'b101, "overrun and data status");
        axw(`SCRO_IDX_INT_EN, 32'h0000_0000);
        chk(irq, 1'b0, "interrupt masked");
        for (int i = 1; i <= 12; i++) begin
            axr(`SCRO_IDX_RX_DATA);
            chk(rd, i, "fifo order");
        end
        axr(`SCRO_IDX_RX_DATA);
        chk(rd, 32'h0000_0000, "empty read");
        axw(`SCRO_IDX_INT_CLR, 32'h0000_0007);
        axr(`SCRO_IDX_INT_STAT);
        chk(rd, 32'h0000_0000, "status cleared");
        axw(`SCRO_IDX_INT_EN, 32'h0000_0007);
        chk(irq, 1'b0, "interrupt clear");
        end_sim();
    end
endmodule
